// ---- hw/csbr_pkg.sv ----
// package: constants, register map and types of the cpu state block
package csbr_pkg;

    // ==========
    // timing
    localparam int CLK_NS = 100;
    localparam int STATE_NS = 100;
    localparam int STATE_CYCLES = (STATE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RELEASE_HIGH_SAMPLES = 2;

    // ==========
    // register map (byte addresses on the axi4-lite port)
    localparam int AXI_AW = 16;
    localparam logic [15:0] REG_PORT_ONE_CONTROL = 16'hfefc;
    localparam logic [15:0] REG_PORT_ONE_DATA = 16'hfef8;
    localparam logic [15:0] REG_STATUS = 16'hfef4;
    localparam int BUS_RELEASE_ENABLE_BIT = 3;
    localparam int P1_ACK_BIT = 2;
    localparam int P1_REQ_BIT = 3;
    localparam logic [7:0] PORT_ONE_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PORT_ONE_DATA_RESET = 8'h00;
    localparam int STAT_RAM_FAULT_BIT = 7;
    localparam int STAT_GHOST_BIT = 6;

    // ==========
    // address areas
    localparam logic [15:0] REG_AREA_LO = 16'hfe80;
    localparam logic [15:0] REG_AREA_HI = 16'hffff;
    localparam logic [15:0] RAM_GUARD_LO = 16'hf67d;
    localparam logic [15:0] RAM_GUARD_HI = 16'hf67f;
    localparam logic [15:0] RAM_START = 16'hf680;
    localparam logic [7:0] RESET_VECTOR = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========
    // types
    typedef enum logic [2:0] {
        ST_RESET, ST_EXEC, ST_EXCEPT, ST_RELEASED, ST_SLEEP, ST_HWSTBY
    } csbr_state_t;

    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } csbr_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } csbr_axi_rsp_t;

    typedef struct packed {
        logic en;
        logic [AXI_AW-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } csbr_reg_wr_t;

    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] data;
        logic rd_n;
        logic wr_n;
        logic rw;
        logic data_strobe_n;
        logic address_strobe_n;
    } csbr_bus_t;

endpackage

// ---- hw/csbr_axil_slave.sv ----
// module: axi4-lite slave front end for the cpu state and bus release registers
module csbr_axil_slave
    import csbr_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire csbr_axi_req_t axi_i,
    output csbr_axi_rsp_t axi_o,
    output csbr_reg_wr_t wr_o,
    input wire logic wr_ok_i,
    output logic [AXI_AW-1:0] rd_addr_o,
    input wire logic [31:0] rd_data_i,
    input wire logic rd_ok_i
);

    // ==========
    // state
    typedef struct packed {
        logic aw_have;
        logic [AXI_AW-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } csbr_slv_t;

    csbr_slv_t s_reg, s_next;

    // ==========
    // handshakes
    always_comb begin
        axi_o.awready = !s_reg.aw_have && !s_reg.bvalid;
        axi_o.wready = !s_reg.w_have && !s_reg.bvalid;
        axi_o.arready = !s_reg.rvalid;
        axi_o.bvalid = s_reg.bvalid;
        axi_o.bresp = s_reg.bresp;
        axi_o.rvalid = s_reg.rvalid;
        axi_o.rdata = s_reg.rdata;
        axi_o.rresp = s_reg.rresp;
        wr_o.en = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
        wr_o.addr = s_reg.aw_addr;
        wr_o.data = s_reg.w_data;
        wr_o.strb = s_reg.w_strb;
        rd_addr_o = axi_i.araddr;
    end

    always_comb begin
        s_next = s_reg;
        if (axi_i.awvalid && axi_o.awready) begin
            s_next.aw_have = 1'b1;
            s_next.aw_addr = axi_i.awaddr;
        end
        if (axi_i.wvalid && axi_o.wready) begin
            s_next.w_have = 1'b1;
            s_next.w_data = axi_i.wdata;
            s_next.w_strb = axi_i.wstrb;
        end
        // write lands while both halves are held, response on the next edge
        if (wr_o.en) begin
            s_next.aw_have = 1'b0;
            s_next.w_have = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = wr_ok_i ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_reg.bvalid && axi_i.bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.rvalid && axi_i.rready) begin
            s_next.rvalid = 1'b0;
        end
        if (axi_i.arvalid && axi_o.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = rd_data_i;
            s_next.rresp = rd_ok_i ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule

// ---- hw/csbr_core.sv ----
// module: cpu operating states with external bus release handshake
// ==========
// Overview of operation
// R1: a low bus request seen at a sampling point starts the bus release
// R2: on release float address, data and strobes, drive acknowledge low, halt
// R3: the external master drives strobes, address and data while it owns the bus
// R4: master raises request when done; device reclaims bus and resumes execution
// R5: request sampled each memory access; low means release at cycle end
// R6: word access to external or register area finishes both bytes first
// R7: during long multiply or divide, request also sampled on internal cycles
// R8: the bus may also be granted while in sleep mode
// R9: no interrupt is accepted while the bus is released
// R10: request sampled once per released-state slot
// R11: request seen high returns acknowledge high and reclaims the bus
// R12: master keeps request low until acknowledge has gone low
// R13: release ends only after two consecutive high samples of request
// R14: release works only with enable set; cleared, pins are general port lines
// R15: enable bit is bit 3 of port one control at fefc, software writable
// R16: with enable cleared, low request levels are not latched
// R17: request plus interrupt at sleep entry may float bus without acknowledge
// R18: reset pin low forces reset state except in hardware standby
// R19: exception pushes pc, sr, code page in maximum mode, clears trace, vectors
// R20: sequential fetch from external memory into on-chip ram is not continued
// R21: outside release, acknowledge stays high whenever release is enabled
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
module csbr_core
    import csbr_pkg::*;
#(
    parameter int STATE_DIV = STATE_CYCLES
)(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire csbr_axi_req_t axi_i,
    output csbr_axi_rsp_t axi_o,
    input wire logic reset_pin_n_i,
    input wire logic hw_standby_i,
    input wire logic bus_request_n_i,
    output logic bus_grant_ack_n_o,
    input wire csbr_bus_t core_bus_i,
    output csbr_bus_t bus_o,
    output logic addr_oe_o,
    output logic data_oe_o,
    output logic ctrl_oe_o,
    input wire logic access_start_i,
    input wire logic access_end_i,
    input wire logic [15:0] access_addr_i,
    input wire logic access_word_i,
    input wire logic access_ext_i,
    input wire logic long_op_i,
    input wire logic sleep_req_i,
    input wire logic insn_end_i,
    input wire logic irq_req_i,
    input wire logic [7:0] irq_vector_i,
    input wire logic exc_req_i,
    input wire logic [7:0] exc_vector_i,
    input wire logic max_mode_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] cp_i,
    input wire logic [15:0] sr_i,
    input wire logic vec_valid_i,
    input wire logic [15:0] vec_data_i,
    input wire logic fetch_i,
    input wire logic fetch_seq_i,
    input wire logic [15:0] fetch_addr_i,
    output logic core_halt_o,
    output logic core_reset_o,
    output logic irq_ack_o,
    output logic trace_clr_o,
    output logic push_valid_o,
    output logic [15:0] push_data_o,
    output logic vec_req_o,
    output logic [15:0] vec_addr_o,
    output logic branch_o,
    output logic [15:0] branch_addr_o,
    output logic fetch_block_o,
    output csbr_state_t cpu_state_o
);

    // ==========
    // state
    typedef struct packed {
        csbr_state_t st;
        logic [7:0] div_cnt;
        logic req_pending;
        logic half_done;
        logic [1:0] high_cnt;
        logic ghost;
        logic ret_sleep;
        logic [2:0] exc_step;
        logic [7:0] exc_vec;
        logic [7:0] p1_ctrl;
        logic [7:0] p1_data;
        logic ram_fault;
        logic prev_ext;
        logic irq_ack;
        logic trace_clr;
        logic push_valid;
        logic [15:0] push_data;
        logic vec_req;
        logic [15:0] vec_addr;
        logic branch;
        logic [15:0] branch_addr;
    } csbr_core_t;

    csbr_core_t c_reg, c_next;

    csbr_reg_wr_t wr;
    logic [AXI_AW-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic wr_ok;
    logic tick;
    logic bus_release_enable;
    logic req_low;
    logic split_first;
    logic released;
    logic fetch_in_ram;

    // ==========
    // register port
    csbr_axil_slave u_slave (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .axi_i(axi_i),
        .axi_o(axi_o),
        .wr_o(wr),
        .wr_ok_i(wr_ok),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .rd_ok_i(rd_ok)
    );

    always_comb begin
        rd_data = 32'h0;
        rd_ok = 1'b1;
        case (rd_addr)
            REG_PORT_ONE_CONTROL: rd_data[7:0] = c_reg.p1_ctrl;
            REG_PORT_ONE_DATA: begin
                rd_data[7:0] = c_reg.p1_data;
                // live request pin level, never latched (R16)
                rd_data[P1_REQ_BIT] = bus_request_n_i;
            end
            REG_STATUS: begin
                rd_data[2:0] = c_reg.st;
                rd_data[STAT_GHOST_BIT] = c_reg.ghost;
                rd_data[STAT_RAM_FAULT_BIT] = c_reg.ram_fault;
            end
            default: rd_ok = 1'b0;
        endcase
        wr_ok = (wr.addr == REG_PORT_ONE_CONTROL) || (wr.addr == REG_PORT_ONE_DATA)
            || (wr.addr == REG_STATUS);
    end

    // ==========
    // decode
    always_comb begin
        // one state per tick; divider keeps a single clock domain
        tick = (c_reg.div_cnt == 8'(STATE_DIV - 1));
        bus_release_enable = c_reg.p1_ctrl[BUS_RELEASE_ENABLE_BIT]; // R14 R15
        req_low = bus_release_enable && !bus_request_n_i; // R16
        // first byte of a split word access must not end in a release
        split_first = access_word_i && !c_reg.half_done
            && (access_ext_i || (access_addr_i >= REG_AREA_LO
            && access_addr_i <= REG_AREA_HI)); // R6
        released = (c_reg.st == ST_RELEASED);
        fetch_in_ram = (fetch_addr_i >= RAM_START) && (fetch_addr_i < REG_AREA_LO);
    end

    // ==========
    // next state
    always_comb begin
        c_next = c_reg;
        c_next.div_cnt = tick ? 8'h00 : c_reg.div_cnt + 8'h01;
        c_next.irq_ack = 1'b0;
        c_next.trace_clr = 1'b0;
        c_next.push_valid = 1'b0;
        c_next.vec_req = 1'b0;
        c_next.branch = 1'b0;

        // register writes, low byte lane only
        if (wr.en && wr.strb[0]) begin
            if (wr.addr == REG_PORT_ONE_CONTROL) begin
                c_next.p1_ctrl = wr.data[7:0]; // R15
            end
            if (wr.addr == REG_PORT_ONE_DATA) begin
                c_next.p1_data = wr.data[7:0];
            end
            if (wr.addr == REG_STATUS && wr.data[STAT_RAM_FAULT_BIT]) begin
                c_next.ram_fault = 1'b0;
            end
        end

        // sequential run from external memory into ram; set beats clear
        if (fetch_i) begin
            if (fetch_seq_i && c_reg.prev_ext && fetch_in_ram) begin
                c_next.ram_fault = 1'b1; // R20
            end
            c_next.prev_ext = (fetch_addr_i >= RAM_GUARD_LO) && (fetch_addr_i <= RAM_GUARD_HI);
        end

        case (c_reg.st)
            ST_EXEC: begin
                if (access_start_i && req_low) begin
                    c_next.req_pending = 1'b1; // R1 R5
                end
                if (access_end_i) begin
                    c_next.half_done = split_first;
                end
                if (sleep_req_i) begin
                    if (req_low && irq_req_i) begin
                        // coincidence at sleep entry floats bus, ack stays high
                        c_next.st = ST_RELEASED; // R17
                        c_next.ghost = 1'b1;
                        c_next.ret_sleep = 1'b0;
                        c_next.high_cnt = 2'h0;
                    end else begin
                        c_next.st = ST_SLEEP;
                    end
                    c_next.req_pending = 1'b0;
                end else if (access_end_i && !split_first
                    && (c_reg.req_pending || (access_start_i && req_low))) begin
                    c_next.st = ST_RELEASED; // R2 R5 R6
                    c_next.req_pending = 1'b0;
                    c_next.ret_sleep = 1'b0;
                    c_next.high_cnt = 2'h0;
                end else if (long_op_i && tick && req_low) begin
                    c_next.st = ST_RELEASED; // R7
                    c_next.ret_sleep = 1'b0;
                    c_next.high_cnt = 2'h0;
                end else if (insn_end_i && exc_req_i) begin
                    c_next.st = ST_EXCEPT;
                    c_next.exc_vec = exc_vector_i;
                    c_next.exc_step = 3'h0;
                end else if (insn_end_i && irq_req_i) begin
                    c_next.st = ST_EXCEPT; // R9
                    c_next.irq_ack = 1'b1;
                    c_next.exc_vec = irq_vector_i;
                    c_next.exc_step = 3'h0;
                end
            end
            ST_SLEEP: begin
                if (tick && req_low) begin
                    c_next.st = ST_RELEASED; // R8
                    c_next.ret_sleep = 1'b1;
                    c_next.high_cnt = 2'h0;
                end else if (irq_req_i) begin
                    c_next.st = ST_EXEC;
                end
            end
            ST_RELEASED: begin
                // one sample per released slot; a low sample restarts the count
                if (tick) begin
                    if (bus_request_n_i) begin // R10
                        c_next.high_cnt = c_reg.high_cnt + 2'h1;
                        if (c_reg.high_cnt == 2'(RELEASE_HIGH_SAMPLES - 1)) begin
                            c_next.st = c_reg.ret_sleep ? ST_SLEEP : ST_EXEC; // R4 R11 R13
                            c_next.ghost = 1'b0;
                            c_next.high_cnt = 2'h0;
                        end
                    end else begin
                        c_next.high_cnt = 2'h0; // R13
                    end
                end
            end
            ST_EXCEPT: begin
                case (c_reg.exc_step)
                    3'h0: begin
                        c_next.push_valid = 1'b1; // R19
                        c_next.push_data = pc_i;
                        c_next.exc_step = max_mode_i ? 3'h1 : 3'h2;
                    end
                    3'h1: begin
                        c_next.push_valid = 1'b1; // R19
                        c_next.push_data = {8'h00, cp_i};
                        c_next.exc_step = 3'h2;
                    end
                    3'h2: begin
                        c_next.push_valid = 1'b1; // R19
                        c_next.push_data = sr_i;
                        c_next.exc_step = 3'h3;
                    end
                    3'h3: begin
                        c_next.trace_clr = 1'b1; // R19
                        c_next.vec_req = 1'b1;
                        c_next.vec_addr = max_mode_i ? {6'h00, c_reg.exc_vec, 2'h0}
                            : {7'h00, c_reg.exc_vec, 1'b0};
                        c_next.exc_step = 3'h4;
                    end
                    3'h4: begin
                        if (vec_valid_i) begin
                            c_next.branch = 1'b1; // R19
                            c_next.branch_addr = vec_data_i;
                            c_next.st = ST_EXEC;
                        end
                    end
                    default: c_next.exc_step = 3'h0;
                endcase
            end
            ST_RESET: begin
                c_next.p1_ctrl = PORT_ONE_CONTROL_RESET;
                c_next.p1_data = PORT_ONE_DATA_RESET;
                c_next.req_pending = 1'b0;
                c_next.half_done = 1'b0;
                c_next.ghost = 1'b0;
                if (reset_pin_n_i) begin
                    // reset skips the stack pushes
                    c_next.st = ST_EXCEPT;
                    c_next.exc_vec = RESET_VECTOR;
                    c_next.exc_step = 3'h3;
                end
            end
            ST_HWSTBY: begin
                if (!hw_standby_i) begin
                    c_next.st = ST_RESET;
                end
            end
            default: c_next.st = ST_RESET;
        endcase

        if (hw_standby_i) begin
            c_next.st = ST_HWSTBY;
        end else if (!reset_pin_n_i && c_reg.st != ST_HWSTBY) begin
            c_next.st = ST_RESET; // R18
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            c_reg <= '0;
        end else begin
            c_reg <= c_next;
        end
    end

    // ==========
    // outputs
    always_comb begin
        if (!bus_release_enable) begin
            bus_grant_ack_n_o = c_reg.p1_data[P1_ACK_BIT]; // R14
        end else begin
            bus_grant_ack_n_o = !(released && !c_reg.ghost); // R2 R11 R17 R21
        end
        // released pins are left to the external master
        addr_oe_o = !released; // R2 R3
        data_oe_o = !released && !core_bus_i.wr_n;
        ctrl_oe_o = !released;
        bus_o = core_bus_i;
        core_halt_o = released || (c_reg.st == ST_SLEEP) || (c_reg.st == ST_HWSTBY); // R2
        core_reset_o = (c_reg.st == ST_RESET); // R18
        irq_ack_o = c_reg.irq_ack;
        trace_clr_o = c_reg.trace_clr;
        push_valid_o = c_reg.push_valid;
        push_data_o = c_reg.push_data;
        vec_req_o = c_reg.vec_req;
        vec_addr_o = c_reg.vec_addr;
        branch_o = c_reg.branch;
        branch_addr_o = c_reg.branch_addr;
        fetch_block_o = fetch_i && fetch_seq_i && c_reg.prev_ext && fetch_in_ram; // R20
        cpu_state_o = c_reg.st;
    end

endmodule

// ---- verif/csbr_core_monitor.sv ----
// checker: bus release and cpu state properties at the core ports
module csbr_core_monitor
    import csbr_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic reset_pin_n_i,
    input wire logic hw_standby_i,
    input wire logic bus_request_n_i,
    input wire logic bus_grant_ack_n_o,
    input wire logic addr_oe_o,
    input wire logic data_oe_o,
    input wire logic ctrl_oe_o,
    input wire logic core_halt_o,
    input wire logic core_reset_o,
    input wire logic irq_ack_o,
    input wire csbr_state_t cpu_state_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // run states only: reset or standby exits are no hand-back
    wire logic rel = cpu_state_o == ST_RELEASED;
    wire logic run = cpu_state_o inside {ST_EXEC, ST_SLEEP};
    // ==========
    // assertions
    a_float_released: assert property (rel |-> !addr_oe_o && !ctrl_oe_o && !data_oe_o && core_halt_o)
        else $error("bus driven while released");
    a_oe_exec: assert property (cpu_state_o == ST_EXEC |-> addr_oe_o && ctrl_oe_o)
        else $error("bus not driven in execution");
    a_enter_low: assert property ($rose(rel) |-> !$past(bus_request_n_i))
        else $error("release without request");
    a_stay_low: assert property (rel && !bus_request_n_i && reset_pin_n_i && !hw_standby_i |=> rel)
        else $error("release left on low request");
    a_exit_two: assert property ($past(rel) && run |-> $past(bus_request_n_i) && $past(bus_request_n_i, 2))
        else $error("release left without two high samples");
    a_exit_ack: assert property ($past(rel) && run |-> bus_grant_ack_n_o)
        else $error("acknowledge low after hand-back");
    a_no_irq: assert property (rel |-> !irq_ack_o)
        else $error("interrupt taken while released");
    a_reset_pin: assert property (!reset_pin_n_i && !hw_standby_i && cpu_state_o != ST_HWSTBY |=> cpu_state_o == ST_RESET && core_reset_o || hw_standby_i)
        else $error("reset pin ignored");
    c_enter: cover property ($rose(rel));
    c_leave: cover property ($fell(rel));
    c_glitch: cover property (rel && bus_request_n_i ##1 rel && !bus_request_n_i);
endmodule
bind csbr_core csbr_core_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i),
    .reset_pin_n_i(reset_pin_n_i), .hw_standby_i(hw_standby_i), .bus_request_n_i(bus_request_n_i),
    .bus_grant_ack_n_o(bus_grant_ack_n_o), .addr_oe_o(addr_oe_o), .data_oe_o(data_oe_o),
    .ctrl_oe_o(ctrl_oe_o), .core_halt_o(core_halt_o), .core_reset_o(core_reset_o),
    .irq_ack_o(irq_ack_o), .cpu_state_o(cpu_state_o));

// ---- verif/csbr_ext_master.sv ----
// partner: external master borrowing the bus by request and acknowledge
module csbr_ext_master (
    input wire logic clk_i,
    input wire logic ack_n_i,
    output logic req_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // request line has a pull-up, so idle is high
    initial req_n_o = 1'b1;
    task automatic own_bus(input bit glitch, input int hold);
        @(posedge clk_i);
        req_n_o <= 1'b0;
        while (ack_n_i !== 1'b0) @(negedge clk_i);
        repeat (hold) @(posedge clk_i);
        if (glitch) begin
            req_n_o <= 1'b1;
            @(posedge clk_i);
            req_n_o <= 1'b0;
            @(posedge clk_i);
        end
        req_n_o <= 1'b1;
    endtask
endmodule

// ---- verif/cpu_state_bus_release_test.sv ----
// testbench: registers and bus release handshake of the cpu state core
module cpu_state_bus_release_test
    import csbr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, nrst_i, rpin_n, stby, st, en, word, ext, lop, slp, iend, irq, exc, mx, vv, ft, fs;
    logic [15:0] aadr, pc, sr, vd, fa;
    logic [7:0] iv, ev, cp;
    logic ack_n, req_n, a_oe, halt, vreq;
    csbr_bus_t cb;
    csbr_axi_req_t aq;
    csbr_axi_rsp_t ar;
    csbr_state_t state;
    int failures, n_compared;
    csbr_core #(.STATE_DIV(1)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .axi_i(aq), .axi_o(ar),
        .reset_pin_n_i(rpin_n), .hw_standby_i(stby), .bus_request_n_i(req_n),
        .bus_grant_ack_n_o(ack_n), .core_bus_i(cb), .bus_o(), .addr_oe_o(a_oe), .data_oe_o(),
        .ctrl_oe_o(), .access_start_i(st), .access_end_i(en), .access_addr_i(aadr),
        .access_word_i(word), .access_ext_i(ext), .long_op_i(lop), .sleep_req_i(slp),
        .insn_end_i(iend), .irq_req_i(irq), .irq_vector_i(iv), .exc_req_i(exc),
        .exc_vector_i(ev), .max_mode_i(mx), .pc_i(pc), .cp_i(cp), .sr_i(sr), .vec_valid_i(vv),
        .vec_data_i(vd), .fetch_i(ft), .fetch_seq_i(fs), .fetch_addr_i(fa),
        .core_halt_o(halt), .core_reset_o(), .irq_ack_o(), .trace_clr_o(), .push_valid_o(),
        .push_data_o(), .vec_req_o(vreq), .vec_addr_o(), .branch_o(), .branch_addr_o(),
        .fetch_block_o(), .cpu_state_o(state));
    csbr_ext_master u_mst (.clk_i(clk_i), .ack_n_i(ack_n), .req_n_o(req_n));
    // ==========
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] rs;
        @(posedge clk_i);
        aq.awaddr <= a;
        aq.wdata <= d;
        aq.wstrb <= 4'hf;
        {aq.awvalid, aq.wvalid, aq.bready} <= 3'b111;
        do begin
            @(negedge clk_i);
            ta = aq.awvalid && ar.awready;
            tw = aq.wvalid && ar.wready;
            tb = ar.bvalid;
            rs = ar.bresp;
            @(posedge clk_i);
            if (ta) aq.awvalid <= 1'b0;
            if (tw) aq.wvalid <= 1'b0;
        end while (!tb);
        aq.bready <= 1'b0;
        chk(32'(rs), 32'(er));
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic tr, tg;
        logic [31:0] d;
        logic [1:0] rs;
        @(posedge clk_i);
        aq.araddr <= a;
        {aq.arvalid, aq.rready} <= 2'b11;
        do begin
            @(negedge clk_i);
            tr = aq.arvalid && ar.arready;
            tg = ar.rvalid;
            d = ar.rdata;
            rs = ar.rresp;
            @(posedge clk_i);
            if (tr) aq.arvalid <= 1'b0;
        end while (!tg);
        aq.rready <= 1'b0;
        chk(d, exp);
        chk(32'(rs), 32'(er));
    endtask
    task automatic acc(input logic w, input logic x, input logic [15:0] a);
        @(posedge clk_i);
        st <= 1'b1;
        {word, ext, aadr} <= {w, x, a};
        @(posedge clk_i);
        st <= 1'b0;
        en <= 1'b1;
        @(posedge clk_i);
        en <= 1'b0;
    endtask
    task automatic wack(input logic lvl);
        while (ack_n !== lvl) @(negedge clk_i);
    endtask
    task automatic boot();
        while (vreq !== 1'b1) @(negedge clk_i);
        @(posedge clk_i);
        vv <= 1'b1;
        @(posedge clk_i);
        vv <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk(32'(state), 32'(ST_EXEC));
    endtask
    task automatic print_verdict();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========
    // clock, watchdog, tests
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        print_verdict();
    end
    initial begin
        failures = 0;
        n_compared = 0;
        nrst_i = 1'b0;
        rpin_n = 1'b1;
        {stby, st, en, word, ext, lop, slp, iend, irq, exc, mx, vv, ft, fs} = '0;
        {aadr, pc, sr, vd, fa, iv, ev, cp} = '0;
        cb = '0;
        aq = '0;
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        boot();
        rd(REG_PORT_ONE_CONTROL, 32'h0, RESP_OKAY);
        rd(16'h0010, 32'h0, RESP_SLVERR);
        // request while disabled is not latched
        fork
            u_mst.own_bus(1'b0, 2);
            acc(1'b0, 1'b0, 16'h8000);
        join
        wr(REG_PORT_ONE_CONTROL, 32'h8, RESP_OKAY);
        rd(REG_PORT_ONE_CONTROL, 32'h8, RESP_OKAY);
        acc(1'b0, 1'b0, 16'h8000);
        @(negedge clk_i);
        chk(32'(state), 32'(ST_EXEC));
        chk(32'(ack_n), 32'h1);
        for (int i = 0; i < 2; i++) begin
            fork
                u_mst.own_bus(1'b1, 4);
                begin
                    acc(1'b1, i == 0, i == 0 ? 16'h2000 : REG_AREA_LO);
                    @(negedge clk_i);
                    chk(32'(ack_n), 32'h1);
                    acc(1'b1, i == 0, i == 0 ? 16'h2001 : REG_AREA_LO + 16'h1);
                    @(negedge clk_i);
                    chk(32'({ack_n, a_oe, halt}), 32'h1);
                    chk(32'(state), 32'(ST_RELEASED));
                end
            join
            wack(1'b1);
            chk(32'(state), 32'(ST_EXEC));
        end
        @(posedge clk_i);
        lop <= 1'b1;
        fork
            u_mst.own_bus(1'b0, 3);
            wack(1'b0);
        join
        chk(32'(state), 32'(ST_RELEASED));
        wack(1'b1);
        chk(32'(state), 32'(ST_EXEC));
        @(posedge clk_i);
        {lop, slp} <= 2'b01;
        @(posedge clk_i);
        slp <= 1'b0;
        u_mst.own_bus(1'b0, 2);
        wack(1'b1);
        rd(REG_STATUS, 32'h4, RESP_OKAY);
        rpin_n <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk(32'(state), 32'(ST_RESET));
        @(posedge clk_i);
        rpin_n <= 1'b1;
        boot();
        rd(REG_PORT_ONE_CONTROL, 32'h0, RESP_OKAY);
        print_verdict();
    end
endmodule
